// ---- rtl/dsc_pkg.sv ----
// Package for the delta-sigma converter control block
// Contract
// - Delta-sigma bitstream decimated into 24-bit result
// - Bit 7 is filter reset, 1 resets
// - Filter held in reset while bit set
// - Reset discards conversion; no partial result
// - No new conversion until reset cleared
// - Bit 6 sleep select, only when powered
// - Powered and awake: conversions run normally
// - Powered with sleep set: enter sleep
// - Sleep keeps only amplifier and bandgap on
// - Bit 5 power-down overrides sleep and reset
// - Bits 4..1 select ratio 32768 down to 256
`default_nettype none
package dsc_pkg;
	localparam int DSC_RES_W = 24;
	localparam logic [7:0] DSC_CTRL0_IDX = 8'h07;
	localparam logic [31:0] DSC_CTRL0_ADDR = {22'h0, DSC_CTRL0_IDX, 2'h0};
	localparam logic [31:0] DSC_STAT_ADDR = 32'h0000_0020;
	localparam logic [31:0] DSC_DATA_ADDR = 32'h0000_0024;
	localparam logic [7:0] DSC_CTRL0_RST = 8'h20;
	localparam int DSC_BIT_FRST = 7;
	localparam int DSC_BIT_SLP = 6;
	localparam int DSC_BIT_OFF = 5;
	localparam int DSC_OSR_LO = 1;
	localparam logic [3:0] DSC_OSR_MAX_CODE = 4'h7;
	localparam int DSC_OSR_BASE_LOG2 = 15;
	localparam int DSC_CNT_W = 16;

	typedef struct packed {
		logic filter_reset_ctl;
		logic sleep_select;
		logic power_down_ctl;
		logic [3:0] oversample_rate_sel;
		logic reference_select;
	} dsc_ctrl_s;

	typedef struct packed {
		logic modulator_en;
		logic amp_en;
		logic bandgap_en;
		logic filter_rst;
	} dsc_pwr_s;

	typedef enum logic [1:0] {
		DSC_OFF = 2'b00,
		DSC_SLEEP = 2'b01,
		DSC_HALT = 2'b10,
		DSC_RUN = 2'b11
	} dsc_mode_e;
endpackage
`default_nettype wire

// ---- rtl/dsc_ctrl.sv ----
// Delta-sigma converter control: register, modes and sinc decimator
`default_nettype none
module dsc_ctrl import dsc_pkg::*; #(
	parameter int RES_W = DSC_RES_W
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	// Modulator bitstream and analog enables
	input wire logic MOD_BIT,
	output dsc_pwr_s PWR_CTL,
	output logic REF_SEL,
	// Result
	output logic [RES_W-1:0] RESULT,
	output logic RESULT_VALID
);
	localparam int ACC_W = 3 * DSC_CNT_W;

	dsc_ctrl_s ctrl_ff, nxt_ctrl;
	logic ack_ff, nxt_ack, err_ff, nxt_err;
	logic [31:0] rdat_ff, nxt_rdat;
	dsc_mode_e mode;
	logic [ACC_W-1:0] i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff;
	logic [ACC_W-1:0] nxt_i1, nxt_i2, nxt_i3, nxt_d1, nxt_d2, nxt_d3;
	logic [DSC_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [1:0] warm_ff, nxt_warm;
	logic [RES_W-1:0] res_ff, nxt_res;
	logic vld_ff, nxt_vld;
	logic [DSC_CNT_W-1:0] ratio_m1;
	logic [4:0] shift;
	logic [ACC_W-1:0] c1, c2, c3;
	logic req, hit_ctl, hit_st, hit_dat;

	assign req = WB_CYC_I && WB_STB_I && !ack_ff && !err_ff;
	assign hit_ctl = WB_ADR_I == DSC_CTRL0_ADDR;
	assign hit_st = WB_ADR_I == DSC_STAT_ADDR;
	assign hit_dat = WB_ADR_I == DSC_DATA_ADDR;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_ack = 1'b0;
		nxt_err = 1'b0;
		nxt_rdat = rdat_ff;
		if (req) begin
			if (hit_ctl || hit_st || hit_dat) begin
				nxt_ack = 1'b1;
				if (WB_WE_I && hit_ctl && WB_SEL_I[0]) begin
					nxt_ctrl = dsc_ctrl_s'(WB_DAT_I[7:0]);
				end
				if (!WB_WE_I) begin
					if (hit_ctl) begin
						nxt_rdat = {24'h0, ctrl_ff};
					end else if (hit_st) begin
						nxt_rdat = {29'h0, vld_ff, mode};
					end else begin
						nxt_rdat = {{(32 - RES_W){1'b0}}, res_ff};
					end
				end
			end else begin
				nxt_err = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_ff <= dsc_ctrl_s'(DSC_CTRL0_RST);
			ack_ff <= 1'b0;
			err_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			ack_ff <= nxt_ack;
			err_ff <= nxt_err;
			rdat_ff <= nxt_rdat;
		end
	end

	assign WB_ACK_O = ack_ff;
	assign WB_ERR_O = err_ff;
	assign WB_DAT_O = rdat_ff;

	// Power-down outranks sleep and filter reset
	always_comb begin
		if (ctrl_ff.power_down_ctl) begin
			mode = DSC_OFF;
		end else if (ctrl_ff.sleep_select) begin
			mode = DSC_SLEEP;
		end else if (ctrl_ff.filter_reset_ctl) begin
			mode = DSC_HALT;
		end else begin
			mode = DSC_RUN;
		end
	end

	// Amplifier and bandgap stay up in sleep for fast common-mode recovery
	always_comb begin
		PWR_CTL.modulator_en = mode == DSC_RUN || mode == DSC_HALT;
		PWR_CTL.amp_en = mode != DSC_OFF;
		PWR_CTL.bandgap_en = mode != DSC_OFF;
		PWR_CTL.filter_rst = mode != DSC_RUN;
	end
	assign REF_SEL = ctrl_ff.reference_select;

	// Codes above 0111 clamp to the smallest ratio
	always_comb begin
		logic [3:0] code;
		code = ctrl_ff.oversample_rate_sel;
		if (code > DSC_OSR_MAX_CODE) begin
			code = DSC_OSR_MAX_CODE;
		end
		ratio_m1 = DSC_CNT_W'((32'h1 << (DSC_OSR_BASE_LOG2 - int'(code))) - 1);
		shift = 5'(3 * (DSC_OSR_BASE_LOG2 - int'(code)) + 1 - RES_W);
	end

	// Third-order sinc: integrators every sample, combs at ratio boundary
	always_comb begin
		c1 = i3_ff - d1_ff;
		c2 = c1 - d2_ff;
		c3 = c2 - d3_ff;
		nxt_i1 = i1_ff + ACC_W'(MOD_BIT);
		nxt_i2 = i2_ff + i1_ff;
		nxt_i3 = i3_ff + i2_ff;
		nxt_d1 = d1_ff;
		nxt_d2 = d2_ff;
		nxt_d3 = d3_ff;
		nxt_cnt = cnt_ff + 1'b1;
		nxt_warm = warm_ff;
		nxt_res = res_ff;
		nxt_vld = 1'b0;
		if (cnt_ff >= ratio_m1) begin
			nxt_cnt = '0;
			nxt_d1 = i3_ff;
			nxt_d2 = c1;
			nxt_d3 = c2;
			// First words after restart are settling, not results
			if (warm_ff == 2'h3) begin
				nxt_res = RES_W'(c3 >> shift);
				nxt_vld = 1'b1;
			end else begin
				nxt_warm = warm_ff + 1'b1;
			end
		end
		if (mode != DSC_RUN) begin
			nxt_i1 = '0;
			nxt_i2 = '0;
			nxt_i3 = '0;
			nxt_d1 = '0;
			nxt_d2 = '0;
			nxt_d3 = '0;
			nxt_cnt = '0;
			nxt_warm = '0;
			nxt_vld = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			i1_ff <= '0;
			i2_ff <= '0;
			i3_ff <= '0;
			d1_ff <= '0;
			d2_ff <= '0;
			d3_ff <= '0;
			cnt_ff <= '0;
			warm_ff <= 2'h0;
			res_ff <= '0;
			vld_ff <= 1'b0;
		end else begin
			i1_ff <= nxt_i1;
			i2_ff <= nxt_i2;
			i3_ff <= nxt_i3;
			d1_ff <= nxt_d1;
			d2_ff <= nxt_d2;
			d3_ff <= nxt_d3;
			cnt_ff <= nxt_cnt;
			warm_ff <= nxt_warm;
			res_ff <= nxt_res;
			vld_ff <= nxt_vld;
		end
	end

	assign RESULT = res_ff;
	assign RESULT_VALID = vld_ff;
endmodule // dsc_ctrl
`default_nettype wire

// ---- tb/dsc_ctrl_monitor.sv ----
// Checker for the converter control block
`default_nettype none
module dsc_ctrl_monitor import dsc_pkg::*; (
	// Watched ports
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic WB_ERR_O,
	input wire dsc_pwr_s PWR_CTL,
	input wire logic RESULT_VALID
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	a_one_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O |=>
		WB_ACK_O ^ WB_ERR_O) else $error("no answer");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack");
	a_ctl_on_ack: assert property ($changed(PWR_CTL) |-> WB_ACK_O)
		else $error("ctl");
	a_run_powered: assert property (PWR_CTL.modulator_en |-> PWR_CTL.amp_en)
		else $error("run");
	a_amp_bandgap: assert property (PWR_CTL.amp_en == PWR_CTL.bandgap_en)
		else $error("amp");
	// Held filter may never hand out a word, even with the modulator up
	a_valid_run: assert property (RESULT_VALID |->
		$past(PWR_CTL.modulator_en && !PWR_CTL.filter_rst))
		else $error("valid");
	a_hold_quiet: assert property (PWR_CTL.filter_rst [*2] |-> !RESULT_VALID)
		else $error("hold");
	a_valid_pulse: assert property (RESULT_VALID |=> !RESULT_VALID) else $error("pulse");
	c_valid: cover property (RESULT_VALID);
	c_err: cover property (WB_ERR_O);
	c_sleep: cover property (PWR_CTL.amp_en && !PWR_CTL.modulator_en);
endmodule // dsc_ctrl_monitor
bind dsc_ctrl dsc_ctrl_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .PWR_CTL(PWR_CTL), .RESULT_VALID(RESULT_VALID));
`default_nettype wire

// ---- tb/tb_dsc_ctrl.sv ----
// Bench for the converter control block
`default_nettype none
module tb_dsc_ctrl import dsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 0, RESET_N = 0, cyc = 0, we = 0, mb = 0, ack, err, rv, rs, ge;
	logic [31:0] adr = 0, di = 0, dout, rd;
	logic [23:0] res;
	dsc_pwr_s pw;
	int err_count = 0, n_compared = 0;
	always #20 CLK = ~CLK;
	always @(posedge CLK) mb <= ~mb;
	dsc_ctrl dut (.CLK(CLK), .RESET_N(RESET_N), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(di), .WB_DAT_O(dout), .WB_ACK_O(ack),
		.WB_ERR_O(err), .MOD_BIT(mb), .PWR_CTL(pw), .REF_SEL(rs), .RESULT(res),
		.RESULT_VALID(rv));
	task chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task wb(input logic w, input logic [31:0] a, d);
		@(posedge CLK);
		cyc <= 1;
		we <= w;
		adr <= a;
		di <= d;
		@(posedge CLK iff (ack | err));
		rd = dout;
		ge = err;
		cyc <= 0;
	endtask
	task wait_valid(output int n);
		n = 0;
		while (rv !== 1 && n < 3000) begin
			@(posedge CLK);
			n++;
		end
	endtask
	task conclude;
		$display("mismatches %0d compares %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task t_reset;
		wb(0, DSC_CTRL0_ADDR, 0);
		chk(rd, 32'h20);
		chk(pw, 4'h1);
	endtask
	task t_rate(input logic [3:0] c, input int r);
		int n;
		wb(1, DSC_CTRL0_ADDR, {c, 1'b1});
		chk(pw[3:1], 3'h7);
		chk(rs, 1);
		wait_valid(n);
		// Three settling samples precede the first result
		chk(n > 3 * r && n < 5 * r, 1);
	endtask
	task t_halt;
		int n;
		wb(1, DSC_CTRL0_ADDR, 32'h8F);
		chk(pw.filter_rst, 1);
		wait_valid(n);
		chk(n, 3000);
		wb(0, DSC_STAT_ADDR, 0);
		chk(rd, 32'h2);
	endtask
	task t_power;
		wb(1, DSC_CTRL0_ADDR, 32'hCE);
		chk(pw[3:1], 3'h3);
		wb(1, DSC_CTRL0_ADDR, 32'hEE);
		chk(pw[3:1], 0);
		wb(0, DSC_CTRL0_ADDR, 0);
		chk(rd, 32'hEE);
		wb(0, 32'h40, 0);
		chk(ge, 1);
	endtask
	initial begin
		repeat (3) @(posedge CLK);
		RESET_N <= 1;
		t_reset;
		t_rate(4'h7, 256);
		t_halt;
		t_rate(4'h6, 512);
		t_power;
		conclude;
	end
	initial begin
		#400000;
		err_count++;
		conclude;
	end
endmodule // tb_dsc_ctrl
`default_nettype wire
